// ---- verilog/expander_pkg.sv ----
/*
 Constants shared by the expander register bank: slave address,
 command codes and power-up values.
 Assumes a single 10 MHz clock domain.
*/
package expander_pkg;
    // ------------------------------------------------------------
    // Slave address
    // ------------------------------------------------------------
    localparam logic [5:0] ADDR_FIXED = 6'h10;
    localparam int         RW_BIT     = 0;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] PTR_IN0   = 8'h00;
    localparam logic [7:0] PTR_IN1   = 8'h01;
    localparam logic [7:0] PTR_OUT0  = 8'h02;
    localparam logic [7:0] PTR_OUT1  = 8'h03;
    localparam logic [7:0] PTR_INV0  = 8'h04;
    localparam logic [7:0] PTR_INV1  = 8'h05;
    localparam logic [7:0] PTR_DIR0  = 8'h06;
    localparam logic [7:0] PTR_DIR1  = 8'h07;
    localparam logic [7:0] PTR_DRV0L = 8'h40;
    localparam logic [7:0] PTR_DRV0H = 8'h41;
    localparam logic [7:0] PTR_DRV1L = 8'h42;
    localparam logic [7:0] PTR_DRV1H = 8'h43;
    localparam logic [7:0] PTR_HLD0  = 8'h44;
    localparam logic [7:0] PTR_HLD1  = 8'h45;
    localparam logic [7:0] PTR_BEN0  = 8'h46;
    localparam logic [7:0] PTR_BEN1  = 8'h47;
    localparam logic [7:0] PTR_BDIR0 = 8'h48;
    localparam logic [7:0] PTR_BDIR1 = 8'h49;
    localparam logic [7:0] PTR_MSK0  = 8'h4a;
    localparam logic [7:0] PTR_MSK1  = 8'h4b;
    localparam logic [7:0] PTR_STA0  = 8'h4c;
    localparam logic [7:0] PTR_STA1  = 8'h4d;
    localparam logic [7:0] PTR_OCFG  = 8'h4f;

    // ------------------------------------------------------------
    // Power-up values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_PTR  = 8'h00;
    localparam logic [7:0] RST_OUT  = 8'hff;
    localparam logic [7:0] RST_INV  = 8'h00;
    localparam logic [7:0] RST_DIR  = 8'hff;
    localparam logic [7:0] RST_DRV  = 8'hff;
    localparam logic [7:0] RST_HLD  = 8'h00;
    localparam logic [7:0] RST_BEN  = 8'h00;
    localparam logic [7:0] RST_BDIR = 8'hff;
    localparam logic [7:0] RST_MSK  = 8'hff;
    localparam logic [7:0] RST_STA  = 8'h00;
    localparam logic [7:0] RST_OCFG = 8'h00;
endpackage

// ---- verilog/line_events.sv ----
/*
 Edge and bus-condition detector for the two serial lines.
 Assumes scl and sda are already synchronous to clk.
*/
module line_events
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_rise,
    output logic      scl_fall,
    output logic      start_seen,
    output logic      stop_seen,
    output logic      sda_now
);
    logic scl_q;
    logic sda_q;

    // ------------------------------------------------------------
    // Previous line levels
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end

    assign scl_rise   = scl & ~scl_q;
    assign scl_fall   = ~scl & scl_q;
    assign start_seen = scl & scl_q & sda_q & ~sda;
    assign stop_seen  = scl & scl_q & ~sda_q & sda;
    assign sda_now    = sda;
endmodule

// ---- verilog/expander_regmap.sv ----
/*
 Serial slave and register bank of a 16-bit I/O expander.
 Assumes scl, sda, addr_sel and port_in are synchronous to clk,
 and that the wire level of sda is resolved outside from sda_oe_n.
*/
module expander_regmap
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        scl,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n,
    input  wire logic        addr_sel,
    input  wire logic [15:0] port_in,
    output logic      [15:0] port_out,
    output logic      [15:0] port_oe_n,
    output logic      [31:0] drive_level,
    output logic      [15:0] hold_change_en,
    output logic      [15:0] bias_resistor_en,
    output logic      [15:0] bias_direction_sel,
    output logic      [7:0]  output_stage_cfg
);
    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_ADDR_ACK, S_CMD, S_CMD_ACK,
        S_WDATA, S_WDATA_ACK, S_RDATA, S_RDATA_ACK
    } slave_state_e;

    slave_state_e state;
    logic        scl_rise, scl_fall;
    logic        ev_start, ev_stop;
    logic        sda_q;
    logic [2:0]  bit_cnt;
    logic        byte_done;
    logic [7:0]  shift;
    logic [7:0]  tx;
    logic [7:0]  pointer;
    logic        rw_read, master_ack;
    logic        drive_low, addr_hit;
    logic        wr_en, load_tx;
    logic        known;
    logic [7:0]  rd_mux;
    logic [15:0] in_view, prev_in, change;
    logic [7:0]  drive_value_out_0, drive_value_out_1;
    logic [7:0]  invert_sel_0, invert_sel_1;
    logic [7:0]  direction_sel_0, direction_sel_1;
    logic [7:0]  drive_level_0_low, drive_level_0_high;
    logic [7:0]  drive_level_1_low, drive_level_1_high;
    logic [7:0]  hold_change_en_0, hold_change_en_1;
    logic [7:0]  bias_resistor_en_0, bias_resistor_en_1;
    logic [7:0]  bias_direction_sel_0, bias_direction_sel_1;
    logic [7:0]  event_block_0, event_block_1;
    logic [7:0]  event_source_0, event_source_1;

    line_events u_lines
    (
        .clk        (clk),
        .rst_n      (rst_n),
        .scl        (scl),
        .sda        (sda_in),
        .scl_rise   (scl_rise),
        .scl_fall   (scl_fall),
        .start_seen (ev_start),
        .stop_seen  (ev_stop),
        .sda_now    (sda_q)
    );

    // ------------------------------------------------------------
    // Serial protocol
    // ------------------------------------------------------------
    assign addr_hit = shift[7:1] == {expander_pkg::ADDR_FIXED, addr_sel};
    assign wr_en    = scl_fall && byte_done && state == S_WDATA;
    assign load_tx  = scl_fall && ((state == S_ADDR_ACK && rw_read) ||
                                   (state == S_RDATA_ACK && master_ack));
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            state <= S_IDLE;
        else if (ev_start)
            state <= S_ADDR;
        else if (ev_stop)
            state <= S_IDLE;
        else if (scl_fall)
        begin
            unique case (state)
                S_IDLE:      state <= S_IDLE;
                S_ADDR:      if (byte_done) state <= addr_hit ? S_ADDR_ACK : S_IDLE;
                S_ADDR_ACK:  state <= rw_read ? S_RDATA : S_CMD;
                S_CMD:       if (byte_done) state <= S_CMD_ACK;
                S_CMD_ACK:   state <= S_WDATA;
                S_WDATA:     if (byte_done) state <= S_WDATA_ACK;
                S_WDATA_ACK: state <= S_WDATA;
                S_RDATA:     if (byte_done) state <= S_RDATA_ACK;
                S_RDATA_ACK: state <= master_ack ? S_RDATA : S_IDLE;
                default:     state <= S_IDLE;
            endcase
        end
    end
    // Bit counting and receive shifting
    always_ff @(posedge clk)
    begin
        if (!rst_n || ev_start)
        begin
            bit_cnt   <= 3'h0;
            byte_done <= 1'b0;
        end
        else if (scl_rise && (state == S_ADDR || state == S_CMD ||
                              state == S_WDATA || state == S_RDATA))
        begin
            bit_cnt   <= bit_cnt + 3'h1;
            byte_done <= bit_cnt == 3'h7;
        end
        else if (scl_fall)
            byte_done <= 1'b0;
    end
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            shift <= 8'h00;
        else if (scl_rise && (state == S_ADDR || state == S_CMD || state == S_WDATA))
            shift <= {shift[6:0], sda_q};
    end
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rw_read <= 1'b0;
        else if (scl_fall && byte_done && state == S_ADDR)
            rw_read <= shift[expander_pkg::RW_BIT];
    end
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            master_ack <= 1'b0;
        else if (scl_rise && state == S_RDATA_ACK)
            master_ack <= !sda_q;
    end
    // Pointer is write only and has no read path
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            pointer <= expander_pkg::RST_PTR;
        else if (scl_fall && byte_done && state == S_CMD)
            pointer <= shift;
    end
    // Transmit byte and data line drive
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            tx <= 8'h00;
        else if (load_tx)
            tx <= rd_mux;
        else if (scl_fall && state == S_RDATA && !byte_done)
            tx <= {tx[6:0], 1'b0};
    end
    always_ff @(posedge clk)
    begin
        if (!rst_n || ev_start || ev_stop)
            drive_low <= 1'b0;
        else if (scl_fall)
            drive_low <= (byte_done && ((state == S_ADDR && addr_hit) ||
                           state == S_CMD || state == S_WDATA)) ||
                         (load_tx && !rd_mux[7]) ||
                         (state == S_RDATA && !byte_done && !tx[6]);
    end
    assign sda_out  = 1'b0;
    assign sda_oe_n = !drive_low;

    // ------------------------------------------------------------
    // Read selection
    // ------------------------------------------------------------
    assign in_view = port_in ^ ({invert_sel_1, invert_sel_0} &
                                {direction_sel_1, direction_sel_0});
    always_comb
    begin
        known = 1'b1;
        unique case (pointer)
            expander_pkg::PTR_IN0:   rd_mux = in_view[7:0];
            expander_pkg::PTR_IN1:   rd_mux = in_view[15:8];
            expander_pkg::PTR_OUT0:  rd_mux = drive_value_out_0;
            expander_pkg::PTR_OUT1:  rd_mux = drive_value_out_1;
            expander_pkg::PTR_INV0:  rd_mux = invert_sel_0;
            expander_pkg::PTR_INV1:  rd_mux = invert_sel_1;
            expander_pkg::PTR_DIR0:  rd_mux = direction_sel_0;
            expander_pkg::PTR_DIR1:  rd_mux = direction_sel_1;
            expander_pkg::PTR_DRV0L: rd_mux = drive_level_0_low;
            expander_pkg::PTR_DRV0H: rd_mux = drive_level_0_high;
            expander_pkg::PTR_DRV1L: rd_mux = drive_level_1_low;
            expander_pkg::PTR_DRV1H: rd_mux = drive_level_1_high;
            expander_pkg::PTR_HLD0:  rd_mux = hold_change_en_0;
            expander_pkg::PTR_HLD1:  rd_mux = hold_change_en_1;
            expander_pkg::PTR_BEN0:  rd_mux = bias_resistor_en_0;
            expander_pkg::PTR_BEN1:  rd_mux = bias_resistor_en_1;
            expander_pkg::PTR_BDIR0: rd_mux = bias_direction_sel_0;
            expander_pkg::PTR_BDIR1: rd_mux = bias_direction_sel_1;
            expander_pkg::PTR_MSK0:  rd_mux = event_block_0;
            expander_pkg::PTR_MSK1:  rd_mux = event_block_1;
            expander_pkg::PTR_STA0:  rd_mux = event_source_0;
            expander_pkg::PTR_STA1:  rd_mux = event_source_1;
            expander_pkg::PTR_OCFG:  rd_mux = output_stage_cfg;
            default:
            begin
                rd_mux = 8'h00;
                known  = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            drive_value_out_0    <= expander_pkg::RST_OUT;
            drive_value_out_1    <= expander_pkg::RST_OUT;
            invert_sel_0         <= expander_pkg::RST_INV;
            invert_sel_1         <= expander_pkg::RST_INV;
            direction_sel_0      <= expander_pkg::RST_DIR;
            direction_sel_1      <= expander_pkg::RST_DIR;
            drive_level_0_low    <= expander_pkg::RST_DRV;
            drive_level_0_high   <= expander_pkg::RST_DRV;
            drive_level_1_low    <= expander_pkg::RST_DRV;
            drive_level_1_high   <= expander_pkg::RST_DRV;
            hold_change_en_0     <= expander_pkg::RST_HLD;
            hold_change_en_1     <= expander_pkg::RST_HLD;
            bias_resistor_en_0   <= expander_pkg::RST_BEN;
            bias_resistor_en_1   <= expander_pkg::RST_BEN;
            bias_direction_sel_0 <= expander_pkg::RST_BDIR;
            bias_direction_sel_1 <= expander_pkg::RST_BDIR;
            event_block_0        <= expander_pkg::RST_MSK;
            event_block_1        <= expander_pkg::RST_MSK;
            output_stage_cfg     <= expander_pkg::RST_OCFG;
        end
        else if (wr_en)
        begin
            // Input and status codes fall to default: read only
            case (pointer)
                expander_pkg::PTR_OUT0:  drive_value_out_0    <= shift;
                expander_pkg::PTR_OUT1:  drive_value_out_1    <= shift;
                expander_pkg::PTR_INV0:  invert_sel_0         <= shift;
                expander_pkg::PTR_INV1:  invert_sel_1         <= shift;
                expander_pkg::PTR_DIR0:  direction_sel_0      <= shift;
                expander_pkg::PTR_DIR1:  direction_sel_1      <= shift;
                expander_pkg::PTR_DRV0L: drive_level_0_low    <= shift;
                expander_pkg::PTR_DRV0H: drive_level_0_high   <= shift;
                expander_pkg::PTR_DRV1L: drive_level_1_low    <= shift;
                expander_pkg::PTR_DRV1H: drive_level_1_high   <= shift;
                expander_pkg::PTR_HLD0:  hold_change_en_0     <= shift;
                expander_pkg::PTR_HLD1:  hold_change_en_1     <= shift;
                expander_pkg::PTR_BEN0:  bias_resistor_en_0   <= shift;
                expander_pkg::PTR_BEN1:  bias_resistor_en_1   <= shift;
                expander_pkg::PTR_BDIR0: bias_direction_sel_0 <= shift;
                expander_pkg::PTR_BDIR1: bias_direction_sel_1 <= shift;
                expander_pkg::PTR_MSK0:  event_block_0        <= shift;
                expander_pkg::PTR_MSK1:  event_block_1        <= shift;
                expander_pkg::PTR_OCFG:  output_stage_cfg     <= shift;
                default:                 ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Change status, cleared by reading the input register
    // ------------------------------------------------------------
    assign change = (port_in ^ prev_in) & {direction_sel_1, direction_sel_0} &
                    ~{event_block_1, event_block_0};
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            prev_in <= 16'h0000;
        else
            prev_in <= port_in;
    end
    // A change in the clearing cycle still sets its bit
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            event_source_0 <= expander_pkg::RST_STA;
            event_source_1 <= expander_pkg::RST_STA;
        end
        else
        begin
            event_source_0 <= (load_tx && pointer == expander_pkg::PTR_IN0 ?
                               8'h00 : event_source_0) | change[7:0];
            event_source_1 <= (load_tx && pointer == expander_pkg::PTR_IN1 ?
                               8'h00 : event_source_1) | change[15:8];
        end
    end

    // ------------------------------------------------------------
    // Pin and feature outputs
    // ------------------------------------------------------------
    assign port_out           = {drive_value_out_1, drive_value_out_0};
    assign port_oe_n          = {direction_sel_1, direction_sel_0};
    assign drive_level        = {drive_level_1_high, drive_level_1_low,
                                 drive_level_0_high, drive_level_0_low};
    assign hold_change_en     = {hold_change_en_1, hold_change_en_0};
    assign bias_resistor_en   = {bias_resistor_en_1, bias_resistor_en_0};
    assign bias_direction_sel = {bias_direction_sel_1, bias_direction_sel_0};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    addr_miss_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == S_ADDR && scl_fall && byte_done && !addr_hit && !ev_start)
        |=> state == S_IDLE && sda_oe_n)
        else $error("foreign address not ignored");
    addr_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == S_ADDR && scl_fall && byte_done && addr_hit && !ev_start)
        |=> state == S_ADDR_ACK && !sda_oe_n)
        else $error("own address not acknowledged");
    dir_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == S_ADDR_ACK && scl_fall && !ev_start && !ev_stop)
        |=> state == ($past(rw_read) ? S_RDATA : S_CMD))
        else $error("direction bit misread");
    ptr_load_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == S_CMD && scl_fall && byte_done)
        |=> pointer == $past(shift))
        else $error("command byte not stored");
    ptr_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(state == S_CMD && scl_fall && byte_done) |=> $stable(pointer))
        else $error("pointer changed without command");
    inv_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_en && pointer == expander_pkg::PTR_INV0)
        |=> invert_sel_0 == $past(shift) ##1 $stable(invert_sel_0) || wr_en)
        else $error("inversion write lost");
    input_view_a: assert property (@(posedge clk) disable iff (!rst_n)
        (load_tx && pointer == expander_pkg::PTR_IN0)
        |=> tx == ($past(port_in[7:0]) ^ ($past(invert_sel_0) & $past(direction_sel_0))))
        else $error("input register view wrong");
    unlisted_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_en && !known)
        |=> $stable(port_out) && $stable(port_oe_n) && $stable(drive_level)
            && $stable(output_stage_cfg) && $stable(bias_resistor_en))
        else $error("unlisted code altered a register");
    reset_vals_a: assert property (@(posedge clk)
        !rst_n |=> port_oe_n == 16'hffff && port_out == 16'hffff
                   && event_source_0 == 8'h00 && event_block_1 == 8'hff
                   && output_stage_cfg == 8'h00 && sda_oe_n)
        else $error("power-up value wrong");
endmodule

// ---- verification/i2c_host.sv ----
/*
 Serial master model for the host side: start, stop and byte transfers.
 Assumes sda_wire is the resolved open-drain level of the data line.
*/
module i2c_host
(
    input  wire logic clk,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Each line phase lasts three clocks
    task automatic step(input logic c, input logic d);
        scl <= c;
        sda <= d;
        repeat (3) @(posedge clk);
    endtask
    task automatic start();
        step(1'b0, sda);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask
    task automatic stop();
        step(1'b0, sda);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
    // Eight bits MSB first, then the ninth bit; a 1 releases the line
    task automatic xfer(input logic [7:0] w, input logic last, output logic [7:0] r,
                        output logic a);
        for (int i = 8; i >= 0; i--)
        begin
            step(1'b0, sda);
            step(1'b0, (i == 0) ? last : w[i - 1]);
            step(1'b1, (i == 0) ? last : w[i - 1]);
            if (i == 0)
                a = sda_wire;
            else
                r[i - 1] = sda_wire;
        end
    endtask
endmodule

// ---- verification/tb_top.sv ----
/*
 Self-checking bench for the expander register bank.
 Assumes the host model i2c_host and the package expander_pkg.
*/
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] RW_C [19] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h40,
        8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h49, 8'h4a, 8'h4b, 8'h4f};
    localparam logic [7:0] RO_C [8] = '{8'h00, 8'h01, 8'h08, 8'h4c, 8'h4d, 8'h4e, 8'h50, 8'hc2};
    logic        clk      = 1'b0;
    logic        rst_n    = 1'b0;
    logic        addr_sel = 1'b0;
    logic [15:0] port_in  = 16'h0000;
    logic        scl;
    logic        sda_host;
    logic        sda_out;
    logic        sda_oe_n;
    logic [15:0] port_out;
    logic [15:0] port_oe_n;
    logic [31:0] drive_level;
    logic [15:0] hold_change_en;
    logic [15:0] bias_resistor_en;
    logic [15:0] bias_direction_sel;
    logic [7:0]  output_stage_cfg;
    logic [7:0]  mem [256];
    logic [15:0] lf = 16'hb75f;
    int          error_cnt = 0;
    int          compares  = 0;
    int          cyc       = 0;
    wire         sda_wire  = sda_host & (sda_oe_n | sda_out);
    i2c_host host (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda(sda_host));
    expander_regmap DUT (.clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_sel(addr_sel), .port_in(port_in),
        .port_out(port_out), .port_oe_n(port_oe_n), .drive_level(drive_level),
        .hold_change_en(hold_change_en), .bias_resistor_en(bias_resistor_en),
        .bias_direction_sel(bias_direction_sel), .output_stage_cfg(output_stage_cfg));
    always #50 clk = ~clk;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] exp_rst(input logic [7:0] c);
        if (c inside {[8'h02:8'h03], [8'h06:8'h07], [8'h40:8'h43], [8'h48:8'h4b]})
            return 8'hff;
        return 8'h00;
    endfunction
    // Inversion only touches pins set as inputs
    function automatic logic [7:0] exp_rd(input logic [7:0] c);
        if (c == 8'h00)
            return port_in[7:0] ^ (mem[4] & mem[6]);
        if (c == 8'h01)
            return port_in[15:8] ^ (mem[5] & mem[7]);
        return mem[c];
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        logic       a;
        host.start();
        host.xfer({expander_pkg::ADDR_FIXED, addr_sel, 1'b0}, 1'b1, r, a);
        check(a, 32'h0);
        host.xfer(c, 1'b1, r, a);
        host.xfer(d, 1'b1, r, a);
        check(a, 32'h0);
        host.stop();
    endtask
    task automatic rdchk(input logic [7:0] c);
        logic [7:0] r;
        logic       a;
        host.start();
        host.xfer({expander_pkg::ADDR_FIXED, addr_sel, 1'b0}, 1'b1, r, a);
        host.xfer(c, 1'b1, r, a);
        host.start();
        host.xfer({expander_pkg::ADDR_FIXED, addr_sel, 1'b1}, 1'b1, r, a);
        check(a, 32'h0);
        host.xfer(8'hff, 1'b0, r, a);
        check(r, exp_rd(c));
        host.xfer(8'hff, 1'b1, r, a);
        check(r, exp_rd(c));
        host.stop();
    endtask
    task automatic bad(input logic [7:0] ad);
        logic [7:0] r;
        logic       a;
        host.start();
        host.xfer(ad, 1'b1, r, a);
        check(a, 32'h1);
        host.stop();
    endtask
    task automatic outs();
        check(sda_oe_n, 32'h1);
        check(port_out, {mem[3], mem[2]});
        check(port_oe_n, {mem[7], mem[6]});
        check(drive_level, {mem[8'h43], mem[8'h42], mem[8'h41], mem[8'h40]});
        check({hold_change_en, bias_resistor_en}, {mem[8'h45], mem[8'h44], mem[8'h47],
              mem[8'h46]});
        check({bias_direction_sel, output_stage_cfg}, {mem[8'h49], mem[8'h48],
              mem[8'h4f]});
    endtask
    task automatic scan();
        for (int i = 0; i < 24; i++)
            rdchk((i < 8) ? 8'(i) : 8'(i + 56));
        outs();
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 80000)
        begin
            error_cnt++;
            wrap_up();
        end
    end
    initial
    begin
        for (int rnd = 0; rnd < 2; rnd++)
        begin
            // New pin levels only while reset keeps every event masked
            lf = lfsr(lf);
            rst_n <= 1'b0;
            port_in <= lf;
            addr_sel <= rnd[0];
            repeat (10) @(posedge clk);
            rst_n <= 1'b1;
            for (int k = 0; k < 256; k++)
                mem[k] = exp_rst(8'(k));
            @(posedge clk);
            scan();
            foreach (RW_C[j])
            begin
                lf = lfsr(lf);
                wr(RW_C[j], lf[7:0]);
                mem[RW_C[j]] = lf[7:0];
            end
            foreach (RO_C[j])
            begin
                lf = lfsr(lf);
                wr(RO_C[j], lf[7:0]);
            end
            scan();
            bad({expander_pkg::ADDR_FIXED, ~addr_sel, 1'b0});
            bad({expander_pkg::ADDR_FIXED ^ 6'h01, addr_sel, 1'b1});
        end
        wrap_up();
    end
endmodule
